// [core/sef_pkg.sv]
package sef_pkg;
    // Command opcodes.
    localparam logic [7:0] CMD_SET_PW = 8'hf1;
    localparam logic [7:0] CMD_UNLOCK = 8'hf2;
    localparam logic [7:0] CMD_ERASE_PREP = 8'hf3;
    localparam logic [7:0] CMD_ERASE_UNIT = 8'hf4;
    localparam logic [7:0] CMD_FREEZE = 8'hf5;
    localparam logic [7:0] CMD_DISABLE_PW = 8'hf6;
    localparam logic [7:0] CMD_FORMAT_UNIT = 8'h50;
    // Error register field positions.
    localparam int ERR_ABORTED_BIT = 2;
    localparam int ERR_ID_NOT_FOUND_BIT = 4;
    // Status register field positions.
    localparam int STS_ERR_BIT = 0;
    localparam int STS_DATA_REQ_BIT = 3;
    localparam int STS_SEEK_BIT = 4;
    localparam int STS_RDY_BIT = 6;
    localparam int STS_BUSY_BIT = 7;
    // Payload layout, in 16-bit words, and bit positions in the control word.
    localparam int PW_FIRST_WORD = 1;
    localparam int PW_LAST_WORD = 16;
    localparam int SECTOR_WORDS = 256;
    localparam int CTL_ID_BIT = 0;
    localparam int CTL_ENH_BIT = 1;
    // Address width of the sector space.
    localparam int LBA_W = 28;
    // Identify word that reports erase time.
    localparam int ID_ERASE_TIME_WORD = 89;
    // Controller register offsets.
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h1;
    localparam logic [3:0] REG_RESULT = 4'h2;
    localparam logic [3:0] REG_IRQ_STAT = 4'h3;
    localparam logic [3:0] REG_IRQ_MASK = 4'h4;
    // Interrupt status bits.
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int IRQ_DATA_REQ_BIT = 2;
    // Reset values.
    localparam logic [7:0] STS_RESET = 8'h50;
    localparam logic [7:0] ERR_RESET = 8'h00;
    typedef enum {DEV_IDLE, DEV_RECV, DEV_CHECK, DEV_ERASE, DEV_DONE}
        sef_dev_state_e;
    typedef enum {HST_IDLE, HST_WAIT, HST_SEND, HST_FIN} sef_hst_state_e;
endpackage

// [core/sef_if.sv]
`timescale 1ns/1ps
// Task-file link between host controller and drive.
interface sef_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic data_valid;
    logic [15:0] data_word;
    logic [7:0] command_status_report;
    logic [7:0] command_error_report;
    logic cmd_done;
    modport dev (input cmd_valid, cmd_code, data_valid, data_word,
                 output command_status_report, command_error_report,
                 cmd_done);
    modport hst (output cmd_valid, cmd_code, data_valid, data_word,
                 input command_status_report, command_error_report,
                 cmd_done);
endinterface

// [core/sef_device.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - F3h arms next erase, no data phase.
// - Host sends prepare right before erase.
// - Host sends prepare right before format.
// - Unarmed erase aborts, data untouched.
// - Erase takes one sector from host.
// - Payload: mode bit, password words 1-16.
// - Identifier bit picks user or master.
// - Password mismatch aborts the erase.
// - Erase spans LBA 0 to native maximum.
// - Writes zeros, no read back.
// - Defect lists stay unchanged.
// - Erase disables lock, keeps master.
// - No compare while lock disabled.
// - Erase time shown in identify word 89.
// - F5h freezes at once, no data.
// - Frozen rejects lock-changing commands.
// - Only power removal clears frozen.
module sef_device (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic power_on_rst,
    // Link to the host.
    sef_if.dev link,
    // Stored secrets and lock state from the security store, plus native maximum address and erase time.
    input wire logic [255:0] user_password,
    input wire logic [255:0] master_password,
    input wire logic lock_enabled,
    input wire logic [sef_pkg::LBA_W-1:0] native_last_block_address,
    input wire logic [15:0] erase_time_minutes,
    // Media write port.
    output logic media_wr,
    output logic [sef_pkg::LBA_W-1:0] media_lba,
    input wire logic media_ready,
    // Effects on the security store and identify data.
    output logic lock_disable,
    output logic frozen,
    output logic [15:0] identify_word_89
);
    import sef_pkg::*;

    sef_dev_state_e state_reg;
    logic armed_reg;
    logic frozen_reg;
    logic [7:0] cmd_reg;
    logic [8:0] word_cnt_reg;
    logic [15:0] ctl_reg;
    logic [255:0] pw_reg;
    logic [LBA_W-1:0] lba_reg;
    logic abort_reg;
    logic idnf_reg;
    logic done_reg;
    logic lock_dis_reg;
    logic pw_match;
    logic lock_cmd;

    // Identify word carries the expected erase time.
    assign identify_word_89 = erase_time_minutes;
    assign frozen = frozen_reg;
    assign lock_disable = lock_dis_reg;
    assign link.cmd_done = done_reg;

    // Commands that change the lock function.
    assign lock_cmd = (link.cmd_code == CMD_SET_PW) ||
        (link.cmd_code == CMD_UNLOCK) ||
        (link.cmd_code == CMD_DISABLE_PW) ||
        (link.cmd_code == CMD_ERASE_UNIT);

    // Password compare selected by the identifier bit.
    always_comb begin
        if (ctl_reg[CTL_ID_BIT]) begin
            pw_match = (pw_reg == master_password);
        end else begin
            pw_match = (pw_reg == user_password);
        end
    end

    // Frozen state only clears on power-on, not on hard reset.
    always_ff @(posedge core_clk) begin
        if (power_on_rst) begin
            frozen_reg <= 1'b0;
        end else if (state_reg == DEV_IDLE && link.cmd_valid &&
                     link.cmd_code == CMD_FREEZE) begin
            frozen_reg <= 1'b1;
        end
    end

    // Prepare arm flag: set by F3h while not frozen, dropped by any other command.
    always_ff @(posedge core_clk) begin
        if (sys_rst || power_on_rst) begin
            armed_reg <= 1'b0;
        end else if (state_reg == DEV_IDLE && link.cmd_valid) begin
            if (link.cmd_code == CMD_ERASE_PREP && !frozen_reg) begin
                armed_reg <= 1'b1;
            end else begin
                armed_reg <= 1'b0;
            end
        end
    end

    // Command sequencer. Only an idle drive takes a command; a command
    // offered while busy or in the data phase is ignored, so the host
    // must wait for completion before it issues the next one. The erase
    // walk always starts at block zero and ignores any host-set limit.
    always_ff @(posedge core_clk) begin
        if (sys_rst || power_on_rst) begin
            state_reg <= DEV_IDLE;
            cmd_reg <= 8'h00;
            word_cnt_reg <= 9'h000;
            ctl_reg <= 16'h0000;
            pw_reg <= '0;
            lba_reg <= '0;
            abort_reg <= 1'b0;
            idnf_reg <= 1'b0;
            done_reg <= 1'b0;
            lock_dis_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            lock_dis_reg <= 1'b0;
            case (state_reg)
                DEV_IDLE: begin
                    if (link.cmd_valid) begin
                        cmd_reg <= link.cmd_code;
                        abort_reg <= 1'b0;
                        idnf_reg <= 1'b0;
                        if (frozen_reg && lock_cmd) begin
                            abort_reg <= 1'b1;
                            state_reg <= DEV_DONE;
                        end else if (link.cmd_code == CMD_ERASE_UNIT) begin
                            word_cnt_reg <= 9'h000;
                            if (!armed_reg) begin
                                abort_reg <= 1'b1;
                                state_reg <= DEV_DONE;
                            end else begin
                                state_reg <= DEV_RECV;
                            end
                        end else begin
                            // Prepare, freeze and others finish at once.
                            state_reg <= DEV_DONE;
                        end
                    end
                end
                DEV_RECV: begin
                    if (link.data_valid) begin
                        word_cnt_reg <= word_cnt_reg + 9'h001;
                        if (word_cnt_reg == 9'h000) begin
                            ctl_reg <= link.data_word;
                        end else if (word_cnt_reg <= 9'(PW_LAST_WORD)) begin
                            // Password words pack low word first
                            pw_reg <= {link.data_word, pw_reg[255:16]};
                        end
                        if (word_cnt_reg == 9'(SECTOR_WORDS - 1)) begin
                            state_reg <= DEV_CHECK;
                        end
                    end
                end
                DEV_CHECK: begin
                    lba_reg <= '0;
                    if (ctl_reg[CTL_ENH_BIT]) begin
                        abort_reg <= 1'b1;
                        state_reg <= DEV_DONE;
                    end else if (lock_enabled && !pw_match) begin
                        abort_reg <= 1'b1;
                        state_reg <= DEV_DONE;
                    end else begin
                        state_reg <= DEV_ERASE;
                    end
                end
                DEV_ERASE: begin
                    // Zero writes only; defect tables are never touched.
                    if (media_ready) begin
                        if (lba_reg == native_last_block_address) begin
                            lock_dis_reg <= 1'b1;
                            state_reg <= DEV_DONE;
                        end else begin
                            lba_reg <= lba_reg + 1'b1;
                        end
                    end
                end
                DEV_DONE: begin
                    done_reg <= 1'b1;
                    state_reg <= DEV_IDLE;
                end
                default: state_reg <= DEV_IDLE;
            endcase
        end
    end

    // Media writes carry zero data during the erase walk.
    assign media_wr = (state_reg == DEV_ERASE);
    assign media_lba = lba_reg;

    // Task-file status and error as seen by the host.
    always_comb begin
        link.command_error_report = ERR_RESET;
        link.command_error_report[ERR_ABORTED_BIT] = abort_reg;
        link.command_error_report[ERR_ID_NOT_FOUND_BIT] = idnf_reg;
        link.command_status_report = STS_RESET;
        link.command_status_report[STS_BUSY_BIT] =
            (state_reg != DEV_IDLE) && (state_reg != DEV_RECV);
        link.command_status_report[STS_DATA_REQ_BIT] =
            (state_reg == DEV_RECV);
        link.command_status_report[STS_ERR_BIT] = abort_reg;
    end
endmodule // sef_device

// [core/sef_host.sv]
`timescale 1ns/1ps
// Host controller: software issues commands and feeds payload words.
module sef_host (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Software register port.
    input wire logic [3:0] sw_addr,
    input wire logic [15:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [15:0] sw_rdata,
    output logic irq,
    // Link to the drive.
    sef_if.hst link
);
    import sef_pkg::*;

    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic [15:0] result_reg;
    logic cmd_valid_reg;
    logic [7:0] cmd_code_reg;
    logic data_valid_reg;
    logic [15:0] data_word_reg;
    logic data_req_seen_reg;
    logic [2:0] ev;

    assign link.cmd_valid = cmd_valid_reg;
    assign link.cmd_code = cmd_code_reg;
    assign link.data_valid = data_valid_reg;
    assign link.data_word = data_word_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Issue orders; software sends prepare right before erase or format.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cmd_valid_reg <= 1'b0;
            cmd_code_reg <= 8'h00;
            data_valid_reg <= 1'b0;
            data_word_reg <= 16'h0000;
        end else begin
            cmd_valid_reg <= sw_wr && sw_addr == REG_CMD;
            data_valid_reg <= sw_wr && sw_addr == REG_DATA;
            if (sw_wr && sw_addr == REG_CMD) begin
                cmd_code_reg <= sw_wdata[7:0];
            end
            if (sw_wr && sw_addr == REG_DATA) begin
                data_word_reg <= sw_wdata;
            end
        end
    end

    // Latch the result and the rising edge of data request.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            result_reg <= 16'h0000;
            data_req_seen_reg <= 1'b0;
        end else begin
            data_req_seen_reg <=
                link.command_status_report[STS_DATA_REQ_BIT];
            if (link.cmd_done) begin
                result_reg <= {link.command_error_report,
                               link.command_status_report};
            end
        end
    end

    // Events: done, error done, new data request.
    always_comb begin
        ev = 3'h0;
        ev[IRQ_DONE_BIT] = link.cmd_done;
        ev[IRQ_ERR_BIT] = link.cmd_done &&
            link.command_status_report[STS_ERR_BIT];
        ev[IRQ_DATA_REQ_BIT] =
            link.command_status_report[STS_DATA_REQ_BIT] &&
            !data_req_seen_reg;
    end

    // Sticky status, write one to clear; a new event wins over the clear.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= 3'h0;
        end else begin
            if (sw_wr && sw_addr == REG_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~sw_wdata[2:0]) | ev;
            end else begin
                irq_stat_reg <= irq_stat_reg | ev;
            end
            if (sw_wr && sw_addr == REG_IRQ_MASK) begin
                irq_mask_reg <= sw_wdata[2:0];
            end
        end
    end

    // Read data one cycle after the strobe, zero otherwise.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sw_rdata <= 16'h0000;
        end else if (sw_rd) begin
            case (sw_addr)
                REG_RESULT: sw_rdata <= result_reg;
                REG_IRQ_STAT: sw_rdata <= {13'h0, irq_stat_reg};
                REG_IRQ_MASK: sw_rdata <= {13'h0, irq_mask_reg};
                default: sw_rdata <= 16'h0000;
            endcase
        end else begin
            sw_rdata <= 16'h0000;
        end
    end
endmodule // sef_host

// [tb/sef_link_monitor.sv]
`timescale 1ns/1ps
// Watches the task-file link between the host controller and the drive.
module sef_link_monitor (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Link signals.
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic data_valid,
    input wire logic [15:0] data_word,
    input wire logic [7:0] command_status_report,
    input wire logic [7:0] command_error_report,
    input wire logic cmd_done
);
    import sef_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic idle;
    logic busy;
    logic aborted;
    logic data_req;
    // A command is taken while the drive is idle and not in a data phase.
    assign busy = command_status_report[STS_BUSY_BIT];
    assign data_req = command_status_report[STS_DATA_REQ_BIT];
    assign idle = !busy && !data_req;
    assign aborted = command_error_report[ERR_ABORTED_BIT];
    // Prepare and freeze finish with no data phase and no error.
    a_prep_no_data: assert property (
        cmd_valid && idle && cmd_code == CMD_ERASE_PREP
        |=> !data_req ##1 cmd_done && !aborted)
        else $error("prepare misbehaved");
    a_freeze_at_once: assert property (
        cmd_valid && idle && cmd_code == CMD_FREEZE
        |=> !data_req ##1 cmd_done && !aborted)
        else $error("freeze misbehaved");
    // An erase that skips its data phase must end aborted.
    a_unarmed_erase: assert property (
        cmd_valid && idle && cmd_code == CMD_ERASE_UNIT ##1 !data_req
        |=> cmd_done && aborted)
        else $error("unarmed erase not aborted");
    // Payload words only flow during the data phase.
    a_payload_in_phase: assert property (
        data_valid |-> data_req)
        else $error("payload word outside data phase");
    // Abort and error bits travel together at completion.
    a_abort_sets_err: assert property (
        cmd_done && aborted |-> command_status_report[STS_ERR_BIT])
        else $error("abort without error");
    a_err_has_abort: assert property (
        cmd_done && command_status_report[STS_ERR_BIT] |-> aborted)
        else $error("error without abort");
    // Completion is a one-cycle pulse with the drive no longer busy.
    a_done_not_busy: assert property (
        cmd_done |-> !busy && !data_req ##1 !cmd_done)
        else $error("bad completion");
    // The error report holds in the cycle after completion if no command is taken then.
    a_report_holds: assert property (
        $fell(cmd_done) && !cmd_valid |-> $stable(command_error_report))
        else $error("error report changed");
    // Main scenarios.
    c_payload: cover property (data_valid);
    c_abort: cover property (cmd_done && aborted);
    c_clean: cover property (cmd_done && !aborted);
endmodule // sef_link_monitor

// [tb/tb_top.sv]
`timescale 1ns/1ps
// Drives both ends of the link through the software port and the store.
module tb_top;
    import sef_pkg::*;
    localparam logic [255:0] USER_PW = {16{16'h1357}};
    localparam logic [255:0] MASTER_PW = {16{16'h2468}};
    localparam logic [27:0] LAST_LBA = 28'h0000009;
    localparam logic [15:0] ERASE_TIME = 16'h0123;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic power_on_rst = 1'b1;
    logic [3:0] sw_addr = 4'h0;
    logic [15:0] sw_wdata = 16'h0000;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic lock_enabled = 1'b1;
    logic media_ready = 1'b0;
    logic [15:0] sw_rdata;
    logic [15:0] rd;
    logic [15:0] id89;
    logic [27:0] media_lba;
    logic irq;
    logic media_wr;
    logic lock_disable;
    logic frozen;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    int n_sect = 0;
    int n_unlock = 0;
    int base;
    sef_if sef_if_i ();
    sef_device sef_device_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .power_on_rst(power_on_rst), .link(sef_if_i.dev),
        .user_password(USER_PW), .master_password(MASTER_PW),
        .lock_enabled(lock_enabled), .native_last_block_address(LAST_LBA),
        .erase_time_minutes(ERASE_TIME), .media_wr(media_wr),
        .media_lba(media_lba), .media_ready(media_ready),
        .lock_disable(lock_disable), .frozen(frozen), .identify_word_89(id89));
    sef_host sef_host_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .irq(irq), .link(sef_if_i.hst));
    sef_link_monitor sef_link_monitor_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .cmd_valid(sef_if_i.cmd_valid),
        .cmd_code(sef_if_i.cmd_code), .data_valid(sef_if_i.data_valid),
        .data_word(sef_if_i.data_word),
        .command_status_report(sef_if_i.command_status_report),
        .command_error_report(sef_if_i.command_error_report),
        .cmd_done(sef_if_i.cmd_done));
    // The clock toggles every half period.
    initial forever #12.5 core_clk = ~core_clk;
    // Media acceptance alternates, sectors and unlock pulses are counted.
    always @(posedge core_clk) begin
        cycles++;
        media_ready <= ~media_ready;
        if (media_wr === 1'b1 && media_ready === 1'b1) n_sect++;
        if (lock_disable === 1'b1) n_unlock++;
        if (cycles == 40000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        if (miscompares == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge core_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge core_clk);
        sw_rd <= 1'b0;
        @(negedge core_clk);
        rd = sw_rdata;
    endtask
    // Waits for completion, then judges the link and the result register.
    task automatic done(input string n, input logic [7:0] err);
        int k;
        logic [15:0] e;
        k = 0;
        while (sef_if_i.cmd_done !== 1'b1 && k < 3000) begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 3000) miscompares++;
        e = {err, STS_RESET | {7'h00, err[ERR_ABORTED_BIT]}};
        chk(n, e, {sef_if_i.command_error_report,
            sef_if_i.command_status_report});
        rdr(REG_RESULT);
        chk(n, e, rd);
    endtask
    task automatic cmd(input string n, input logic [7:0] op,
        input logic [7:0] err);
        wr(REG_CMD, {8'h00, op});
        done(n, err);
    endtask
    task automatic erase(input logic [15:0] ctl, input logic [255:0] pw,
        input logic [7:0] err);
        logic [7:0] sts;
        base = n_sect;
        cmd("prep", CMD_ERASE_PREP, 8'h00);
        wr(REG_CMD, {8'h00, CMD_ERASE_UNIT});
        repeat (3) @(negedge core_clk);
        sts = sef_if_i.command_status_report;
        chk("data req", 16'h0001, {15'h0, sts[STS_DATA_REQ_BIT]});
        for (int i = 0; i < SECTOR_WORDS; i++) begin
            if (i == 0) wr(REG_DATA, ctl);
            else if (i <= PW_LAST_WORD) wr(REG_DATA, pw[16*(i-1) +: 16]);
            else wr(REG_DATA, 16'h0000);
        end
        done("erase", err);
        chk("sectors", (err == 0) ? 16'(LAST_LBA) + 16'h1 : 16'h0,
            16'(n_sect - base));
    endtask
    task automatic t_reset();
        chk("rst", {ERR_RESET, STS_RESET}, {sef_if_i.command_error_report,
            sef_if_i.command_status_report});
        rdr(4'hf);
        chk("unmapped", 16'h0000, rd);
        chk("id89", ERASE_TIME, id89);
    endtask
    task automatic t_erase_paths();
        int unl0;
        cmd("unarmed", CMD_ERASE_UNIT, 8'h04);
        erase(16'h0000, MASTER_PW, 8'h04);
        erase(16'h0003, MASTER_PW, 8'h04);
        unl0 = n_unlock;
        erase(16'h0001, MASTER_PW, 8'h00);
        chk("unlock", 16'h0001, 16'(n_unlock - unl0));
        @(posedge core_clk);
        lock_enabled <= 1'b0;
        erase(16'h0000, 256'h0, 8'h00);
        @(posedge core_clk);
        lock_enabled <= 1'b1;
        cmd("prep", CMD_ERASE_PREP, 8'h00);
        cmd("format", CMD_FORMAT_UNIT, 8'h00);
        cmd("disarmed", CMD_ERASE_UNIT, 8'h04);
    endtask
    task automatic t_irq();
        wr(REG_IRQ_STAT, 16'h0007);
        wr(REG_IRQ_MASK, 16'h0003);
        cmd("irq cmd", CMD_ERASE_PREP, 8'h00);
        chk("irq on", 16'h0001, {15'h0, irq});
        rdr(REG_IRQ_STAT);
        chk("irq stat", 16'h0001, rd);
        wr(REG_IRQ_STAT, 16'h0007);
        @(negedge core_clk);
        chk("irq off", 16'h0000, {15'h0, irq});
        wr(REG_IRQ_MASK, 16'h0000);
        cmd("masked", CMD_FORMAT_UNIT, 8'h00);
        chk("irq mask", 16'h0000, {15'h0, irq});
        cmd("irq err", CMD_ERASE_UNIT, 8'h04);
        rdr(REG_IRQ_STAT);
        chk("irq err stat", 16'h0003, rd);
        wr(REG_IRQ_STAT, 16'h0007);
    endtask
    task automatic t_freeze();
        logic [7:0] ops [4] = '{CMD_SET_PW, CMD_UNLOCK, CMD_DISABLE_PW,
            CMD_ERASE_UNIT};
        cmd("freeze", CMD_FREEZE, 8'h00);
        chk("frozen", 16'h0001, {15'h0, frozen});
        foreach (ops[i]) cmd("frozen op", ops[i], 8'h04);
        cmd("prep", CMD_ERASE_PREP, 8'h00);
        cmd("frozen erase", CMD_ERASE_UNIT, 8'h04);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        chk("hard rst", 16'h0001, {15'h0, frozen});
        @(posedge core_clk);
        power_on_rst <= 1'b1;
        @(posedge core_clk);
        power_on_rst <= 1'b0;
        @(negedge core_clk);
        chk("power rst", 16'h0000, {15'h0, frozen});
    endtask
    // Main sequence.
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        power_on_rst <= 1'b0;
        @(negedge core_clk);
        t_reset();
        t_erase_paths();
        t_irq();
        t_freeze();
        conclude();
    end
endmodule // tb_top
